// ---- clmb_pkg.sv ----
// Shared constants and types of the layer-2 message mailbox.
package clmb_pkg;
    localparam int unsigned TX_DEPTH_DEF   = 10;
    localparam int unsigned RX_DEPTH_DEF   = 10;
    localparam int unsigned CNT_W          = 8;
    localparam int unsigned FIFO_DEPTH_DEF = 4;
    localparam int unsigned MAX_LEN        = 8;
    localparam int unsigned ID_LSB         = 0;
    localparam int unsigned ID_MSB         = 28;
    localparam int unsigned STD_ID_MSB     = 10;
    localparam int unsigned RSV_BIT        = 29;
    localparam int unsigned RTR_BIT        = 30;
    localparam int unsigned EXT_BIT        = 31;
    localparam logic [15:0] RESTART_PORT   = 16'h00C8;
    localparam logic [15:0] NODE_PORT_BASE = 16'h1000;
    localparam logic [15:0] RUN_CODE       = 16'h0005;
    localparam logic [15:0] STOP_CODE      = 16'h0006;
    localparam logic [15:0] DSV_ZERO       = 16'h0000;
    localparam logic [15:0] DSV_OP_RESET   = 16'h0001;
    localparam logic [15:0] DSV_PREOP      = 16'h0002;
    localparam logic [15:0] DSV_OP         = 16'h0003;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

    typedef struct packed {
        logic [3:0]  length;
        logic [31:0] id_word;
        logic [63:0] data;
    } clmb_entry_s;

    localparam int unsigned ENTRY_W = $bits(clmb_entry_s);

    typedef enum logic [2:0] {
        NMT_NONE, NMT_TO_PREOP, NMT_TO_OP_RESET, NMT_TO_OP, NMT_TO_STOP
    } clmb_nmt_e;

    function automatic clmb_entry_s clmb_clean(input clmb_entry_s e);
        clmb_entry_s r;
        r = e;
        if (e.length > 4'(MAX_LEN)) begin
            r.length = 4'(MAX_LEN);
        end
        r.id_word[RSV_BIT] = 1'b0;
        if (!e.id_word[EXT_BIT]) begin
            r.id_word[ID_MSB:STD_ID_MSB+1] = '0;
        end
        return r;
    endfunction
endpackage

// ---- clmb_stream_if.sv ----
// Valid-ready stream carrier between the mailbox and its FIFO.
`timescale 1ns/1ps
interface clmb_stream_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- clmb_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module clmb_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic   core_clk,
    input wire logic   rstn,
    clmb_stream_if.snk in_s,
    clmb_stream_if.src out_s
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("clmb_fifo needs DEPTH of at least 2.");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      level;
    wire              push = in_s.valid && in_s.ready;
    wire              pop  = out_s.valid && out_s.ready;
    wire [AW-1:0]     wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0]     rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_s.ready  = (level != (AW+1)'(DEPTH));
    assign out_s.valid = (level != '0);
    assign out_s.data  = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) wr_ptr <= wr_inc;
            if (pop) rd_ptr <= rd_inc;
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // clmb_fifo

// ---- clmb_mailbox.sv ----
// Layer-2 CAN message mailbox with counter handshakes toward the host.
//
// What this block does
// - Pass any CAN frame both ways, protocol-blind.
// - Support 11-bit and 29-bit identifiers.
// - Identifier word: id 0-28, RTR 30, extended 31.
// - Entry holds length 0 to 8 and eight bytes.
// - Receive counter differs until host acknowledges batch.
// - Stop 6/0 stops; run 5/2 goes pre-operational.
// - Run 5 value 1 resets, value 3 not.
`timescale 1ns/1ps
module clmb_mailbox
    import clmb_pkg::*;
#(
    parameter int unsigned TX_DEPTH   = TX_DEPTH_DEF,
    parameter int unsigned RX_DEPTH   = RX_DEPTH_DEF,
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             tx_wr_en,
    input  wire logic [3:0]       tx_wr_index,
    input  wire clmb_entry_s      tx_wr_entry,
    input  wire logic [3:0]       tx_message_count,
    input  wire logic [CNT_W-1:0] tx_handover_counter,
    output logic [CNT_W-1:0]      tx_handover_counter_ret,
    input  wire logic [3:0]       rx_rd_index,
    output clmb_entry_s           rx_rd_entry,
    output logic [3:0]            rx_message_count,
    output logic [CNT_W-1:0]      rx_handover_counter,
    input  wire logic [CNT_W-1:0] rx_handover_counter_ack,
    input  wire logic             ctl_valid,
    input  wire logic [15:0]      ctl_port,
    input  wire logic [15:0]      ctl_state_code,
    input  wire logic [15:0]      device_state_value,
    output logic                  nmt_valid,
    output logic [6:0]            nmt_node,
    output clmb_nmt_e             nmt_action,
    output logic                  if_running,
    output logic                  can_tx_valid,
    input  wire logic             can_tx_ready,
    output clmb_entry_s           can_tx_entry,
    input  wire logic             can_rx_valid,
    output logic                  can_rx_ready,
    input  wire clmb_entry_s      can_rx_entry
);
    generate
        if (TX_DEPTH < 1 || TX_DEPTH > 15 || RX_DEPTH < 1 || RX_DEPTH > 15) begin : g_bad
            $error("clmb_mailbox buffer depths must lie in 1 to 15.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // Transmit buffer, batch sequencer and FIFO toward the CAN side.
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DRAIN} clmb_tx_e;

    clmb_entry_s      tx_buf [TX_DEPTH];
    clmb_tx_e         tx_state;
    logic [3:0]       tx_idx;
    logic [3:0]       tx_last;
    logic [CNT_W-1:0] tx_target;

    clmb_stream_if #(.W(ENTRY_W)) fifo_in ();
    clmb_stream_if #(.W(ENTRY_W)) fifo_out ();

    wire         tx_new   = if_running && (tx_handover_counter != tx_handover_counter_ret);
    wire [3:0]   tx_count = (tx_message_count > 4'(TX_DEPTH)) ? 4'(TX_DEPTH) : tx_message_count;
    wire         tx_push  = (tx_state == TX_SEND) && fifo_in.ready;
    wire         tx_done  = (tx_state == TX_DRAIN) && !fifo_out.valid;

    assign fifo_in.valid  = (tx_state == TX_SEND);
    assign fifo_in.data   = clmb_clean(tx_buf[tx_idx]);
    assign can_tx_valid   = fifo_out.valid;
    assign can_tx_entry   = fifo_out.data;
    assign fifo_out.ready = can_tx_ready;

    clmb_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .rstn     (rstn),
        .in_s     (fifo_in),
        .out_s    (fifo_out)
    );

    always_ff @(posedge core_clk) begin
        if (tx_wr_en && tx_wr_index < 4'(TX_DEPTH)) begin
            tx_buf[tx_wr_index] <= tx_wr_entry;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_state                <= TX_IDLE;
            tx_idx                  <= 4'h0;
            tx_last                 <= 4'h0;
            tx_target               <= CNT_RESET;
            tx_handover_counter_ret <= CNT_RESET;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_new) begin
                        tx_target <= tx_handover_counter;
                        tx_idx    <= 4'h0;
                        tx_last   <= tx_count - 4'h1;
                        tx_state  <= (tx_count == 4'h0) ? TX_DRAIN : TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_push) begin
                        tx_idx <= tx_idx + 4'h1;
                        if (tx_idx == tx_last) begin
                            tx_state <= TX_DRAIN;
                        end
                    end
                end
                TX_DRAIN: begin
                    if (tx_done) begin
                        tx_handover_counter_ret <= tx_target;
                        tx_state                <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive buffer and hand-over to the host.
    clmb_entry_s rx_buf [RX_DEPTH];
    logic [3:0]  rx_fill;

    wire rx_owned   = (rx_handover_counter == rx_handover_counter_ack);
    wire rx_take    = can_rx_valid && can_rx_ready;
    wire rx_publish = rx_owned && (rx_fill != 4'h0) && !rx_take &&
                      (!can_rx_valid || rx_fill == 4'(RX_DEPTH));

    assign can_rx_ready = if_running && rx_owned && (rx_fill < 4'(RX_DEPTH));

    always_ff @(posedge core_clk) begin
        if (rx_take) begin
            rx_buf[rx_fill] <= clmb_clean(can_rx_entry);
        end
        rx_rd_entry <= rx_buf[(rx_rd_index < 4'(RX_DEPTH)) ? rx_rd_index : 4'h0];
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_fill             <= 4'h0;
            rx_message_count    <= 4'h0;
            rx_handover_counter <= CNT_RESET;
        end else if (!if_running) begin
            rx_fill <= 4'h0;
        end else if (rx_take) begin
            rx_fill <= rx_fill + 4'h1;
        end else if (rx_publish) begin
            rx_message_count    <= rx_fill;
            rx_handover_counter <= rx_handover_counter + CNT_W'(1);
            rx_fill             <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Control writes: interface restart and node state changes.
    wire       port_restart = (ctl_port == RESTART_PORT);
    wire       port_node    = (ctl_port[15:7] == NODE_PORT_BASE[15:7]) && (ctl_port[6:0] != 7'h00);
    wire       is_run       = (ctl_state_code == RUN_CODE);
    wire       is_stop      = (ctl_state_code == STOP_CODE);
    clmb_nmt_e next_action;

    always_comb begin
        next_action = NMT_NONE;
        if (is_stop && device_state_value == DSV_ZERO) begin
            next_action = NMT_TO_STOP;
        end else if (is_run) begin
            case (device_state_value)
                DSV_ZERO:     next_action = NMT_TO_PREOP;
                DSV_PREOP:    next_action = NMT_TO_PREOP;
                DSV_OP_RESET: next_action = NMT_TO_OP_RESET;
                DSV_OP:       next_action = NMT_TO_OP;
                default:      next_action = NMT_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            if_running <= 1'b1;
            nmt_valid  <= 1'b0;
            nmt_node   <= 7'h00;
            nmt_action <= NMT_NONE;
        end else begin
            nmt_valid <= ctl_valid && port_node && (next_action != NMT_NONE);
            if (ctl_valid && port_node) begin
                nmt_node   <= ctl_port[6:0];
                nmt_action <= next_action;
            end
            if (ctl_valid && port_restart && is_stop) begin
                if_running <= 1'b0;
            end else if (ctl_valid && port_restart && is_run) begin
                if_running <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_tx_stable;
        @(posedge core_clk) disable iff (!rstn)
        can_tx_valid && !can_tx_ready |=> can_tx_valid && $stable(can_tx_entry);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("Tx frame changed in stall.");

    property p_std_id;
        @(posedge core_clk) disable iff (!rstn)
        can_tx_valid && !can_tx_entry.id_word[EXT_BIT] |-> can_tx_entry.id_word[28:11] == 18'h0;
    endproperty
    a_std_id: assert property (p_std_id) else $error("Standard frame has high id bits.");

    property p_rsv_bit;
        @(posedge core_clk) disable iff (!rstn)
        can_tx_valid |-> !can_tx_entry.id_word[RSV_BIT];
    endproperty
    a_rsv_bit: assert property (p_rsv_bit) else $error("Reserved id bit set.");

    property p_len;
        @(posedge core_clk) disable iff (!rstn)
        can_tx_valid |-> can_tx_entry.length <= 4'h8 && rx_message_count <= 4'(RX_DEPTH);
    endproperty
    a_len: assert property (p_len) else $error("Length above eight.");

    property p_rx_step;
        @(posedge core_clk) disable iff (!rstn)
        $changed(rx_handover_counter) |->
            rx_handover_counter == $past(rx_handover_counter) + CNT_W'(1) &&
            rx_message_count != 4'h0;
    endproperty
    a_rx_step: assert property (p_rx_step) else $error("Bad receive hand-over.");

    property p_rx_hold;
        @(posedge core_clk) disable iff (!rstn)
        rx_handover_counter != rx_handover_counter_ack |->
            !can_rx_ready ##1 $stable(rx_message_count);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("Receive buffer touched while lent.");

    property p_nmt_stop;
        @(posedge core_clk) disable iff (!rstn)
        ctl_valid && port_node && is_stop && device_state_value == 16'h0000 |=>
            nmt_valid && nmt_action == NMT_TO_STOP;
    endproperty
    a_nmt_stop: assert property (p_nmt_stop) else $error("Stop command not issued.");

    property p_nmt_op;
        @(posedge core_clk) disable iff (!rstn)
        ctl_valid && port_node && is_run && device_state_value == 16'h0001 |=>
            nmt_valid && nmt_action == NMT_TO_OP_RESET;
    endproperty
    a_nmt_op: assert property (p_nmt_op) else $error("Operational with reset not issued.");

    property p_tx_ack;
        @(posedge core_clk) disable iff (!rstn)
        $changed(tx_handover_counter_ret) |->
            tx_handover_counter_ret == tx_target && !can_tx_valid;
    endproperty
    a_tx_ack: assert property (p_tx_ack) else $error("Tx batch acknowledged early.");
endmodule // clmb_mailbox

// ---- clmb_can_node.sv ----
// Behavioural CAN bus node facing the mailbox.
`timescale 1ns/1ps
module clmb_can_node
    import clmb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        stall,
    input  wire logic        can_tx_valid,
    output logic             can_tx_ready,
    input  wire clmb_entry_s can_tx_entry,
    output logic             can_rx_valid,
    input  wire logic        can_rx_ready,
    output clmb_entry_s      can_rx_entry
);
    clmb_entry_s got[$];
    assign can_tx_ready = !stall;
    initial begin
        can_rx_valid = 1'b0;
        can_rx_entry = '0;
    end
    // Every frame taken from the mailbox is kept whole in arrival order.
    always @(posedge core_clk) begin
        if (can_tx_valid && can_tx_ready) begin
            got.push_back(can_tx_entry);
        end
    end
    // Offers one frame and holds it until the edge that accepts it, waiting at most 100 cycles for ready.
    task automatic send(input clmb_entry_s e, input bit last);
        int n;
        n = 0;
        can_rx_valid = 1'b1;
        can_rx_entry = e;
        @(negedge core_clk);
        while (!can_rx_ready && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        @(posedge core_clk);
        #1;
        if (last) begin
            can_rx_valid = 1'b0;
            can_rx_entry = ~e;
        end
    endtask
endmodule // clmb_can_node

// ---- tb.sv ----
// Self-checking testbench of the layer-2 message mailbox.
`timescale 1ns/1ps
module tb
    import clmb_pkg::*;
();
    logic             core_clk = 1'b0;
    logic             rstn = 1'b0;
    logic             stall = 1'b0;
    logic             tx_wr_en = 1'b0;
    logic [3:0]       tx_wr_index = 4'h0;
    clmb_entry_s      tx_wr_entry = '0;
    logic [3:0]       tx_message_count = 4'h0;
    logic [CNT_W-1:0] tx_handover_counter = 8'h00;
    logic [CNT_W-1:0] tx_handover_counter_ret, rx_handover_counter;
    logic [3:0]       rx_rd_index = 4'h0;
    clmb_entry_s      rx_rd_entry, can_tx_entry, can_rx_entry;
    logic [3:0]       rx_message_count;
    logic [CNT_W-1:0] rx_handover_counter_ack = 8'h00;
    logic             ctl_valid = 1'b0;
    logic [15:0]      ctl_port = 16'h0000;
    logic [15:0]      ctl_state_code = 16'h0000;
    logic [15:0]      device_state_value = 16'h0000;
    logic [6:0]       nmt_node;
    clmb_nmt_e        nmt_action;
    logic             nmt_valid, if_running, can_tx_valid, can_tx_ready;
    logic             can_rx_valid, can_rx_ready;
    int               fail_count = 0;
    int               compares = 0;
    int               cyc = 0;

    always #10 core_clk = ~core_clk;

    clmb_mailbox u_dut (.core_clk(core_clk), .rstn(rstn), .tx_wr_en(tx_wr_en),
        .tx_wr_index(tx_wr_index), .tx_wr_entry(tx_wr_entry),
        .tx_message_count(tx_message_count), .tx_handover_counter(tx_handover_counter),
        .tx_handover_counter_ret(tx_handover_counter_ret), .rx_rd_index(rx_rd_index),
        .rx_rd_entry(rx_rd_entry), .rx_message_count(rx_message_count),
        .rx_handover_counter(rx_handover_counter),
        .rx_handover_counter_ack(rx_handover_counter_ack), .ctl_valid(ctl_valid),
        .ctl_port(ctl_port), .ctl_state_code(ctl_state_code),
        .device_state_value(device_state_value), .nmt_valid(nmt_valid),
        .nmt_node(nmt_node), .nmt_action(nmt_action), .if_running(if_running),
        .can_tx_valid(can_tx_valid), .can_tx_ready(can_tx_ready),
        .can_tx_entry(can_tx_entry), .can_rx_valid(can_rx_valid),
        .can_rx_ready(can_rx_ready), .can_rx_entry(can_rx_entry));

    clmb_can_node u_node (.core_clk(core_clk), .stall(stall), .can_tx_valid(can_tx_valid),
        .can_tx_ready(can_tx_ready), .can_tx_entry(can_tx_entry),
        .can_rx_valid(can_rx_valid), .can_rx_ready(can_rx_ready),
        .can_rx_entry(can_rx_entry));

    ////////////////////////////////////////
    task automatic check(input logic [99:0] seen, input logic [99:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_ret();
        int n;
        n = 0;
        while (tx_handover_counter_ret !== tx_handover_counter && n < 300) begin
            n++;
            tick(1);
        end
        check(tx_handover_counter_ret, tx_handover_counter);
    endtask

    task automatic ctl(input logic [15:0] port, code, dsv, input clmb_nmt_e exp,
                       input logic pulse);
        logic      seen;
        clmb_nmt_e act;
        logic [6:0] nd;
        seen = 1'b0;
        act = NMT_NONE;
        nd = 7'h00;
        ctl_port = port;
        ctl_state_code = code;
        device_state_value = dsv;
        ctl_valid = 1'b1;
        tick(1);
        ctl_valid = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (nmt_valid === 1'b1) begin
                seen = 1'b1;
                act = nmt_action;
                nd = nmt_node;
            end
            tick(1);
        end
        check(seen, pulse);
        if (pulse) begin
            check(act, exp);
            check(nd, port[6:0]);
        end
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        check(tx_handover_counter_ret, 8'h00);
        check(rx_handover_counter, 8'h00);
        check(rx_message_count, 4'h0);
        check(if_running, 1'b1);
    endtask

    task automatic t_tx();
        logic [31:0] idi[6] = '{32'h2ABCD123, 32'hDFFFFFFF, 32'hB0000001,
                                32'h400007FF, 32'h80000000, 32'h00000000};
        logic [31:0] ide[6] = '{32'h00000123, 32'hDFFFFFFF, 32'h90000001,
                                32'h400007FF, 32'h80000000, 32'h00000000};
        logic [3:0]  lni[6] = '{4'h8, 4'h0, 4'hC, 4'h1, 4'h8, 4'h0};
        check(tx_handover_counter_ret, tx_handover_counter);
        stall = 1'b1;
        for (int i = 0; i < 6; i++) begin
            tx_wr_en = 1'b1;
            tx_wr_index = 4'(i);
            tx_wr_entry = {lni[i], idi[i], {8{8'hA0 + 8'(i)}}};
            tick(1);
        end
        tx_wr_en = 1'b0;
        tx_message_count = 4'h6;
        tx_handover_counter = tx_handover_counter + 8'h01;
        tick(30);
        check(tx_handover_counter_ret, tx_handover_counter - 8'h01);
        stall = 1'b0;
        wait_ret();
        check(100'(u_node.got.size()), 100'h6);
        for (int i = 0; i < 6; i++) begin
            check(u_node.got[i], {(lni[i] > 4'h8) ? 4'h8 : lni[i], ide[i],
                                  {8{8'hA0 + 8'(i)}}});
        end
        tx_message_count = 4'h0;
        tx_handover_counter = tx_handover_counter + 8'h01;
        wait_ret();
        check(100'(u_node.got.size()), 100'h6);
    endtask

    task automatic t_rx();
        clmb_entry_s a, b;
        int n;
        a = {4'h3, 32'h00000456, 64'h0011223344556677};
        b = {4'h8, 32'hDABCDEF0, 64'h8899AABBCCDDEEFF};
        n = 0;
        u_node.send(a, 1'b0);
        u_node.send(b, 1'b1);
        while (rx_handover_counter === rx_handover_counter_ack && n < 50) begin
            n++;
            tick(1);
        end
        check(rx_handover_counter, rx_handover_counter_ack + 8'h01);
        check(rx_message_count, 4'h2);
        check(can_rx_ready, 1'b0);
        rx_rd_index = 4'h0;
        tick(2);
        check(rx_rd_entry, a);
        rx_rd_index = 4'h1;
        tick(2);
        check(rx_rd_entry, b);
        rx_handover_counter_ack = rx_handover_counter;
        tick(3);
        check(rx_handover_counter, rx_handover_counter_ack);
        check(can_rx_ready, 1'b1);
    endtask

    task automatic t_ctl();
        ctl(NODE_PORT_BASE + 16'h0005, STOP_CODE, DSV_ZERO, NMT_TO_STOP, 1'b1);
        ctl(16'h1005, RUN_CODE, DSV_PREOP, NMT_TO_PREOP, 1'b1);
        ctl(16'h1005, RUN_CODE, DSV_ZERO, NMT_TO_PREOP, 1'b1);
        ctl(16'h107F, RUN_CODE, DSV_OP_RESET, NMT_TO_OP_RESET, 1'b1);
        ctl(16'h1001, RUN_CODE, DSV_OP, NMT_TO_OP, 1'b1);
        ctl(16'h1001, RUN_CODE, 16'h0007, NMT_NONE, 1'b0);
        ctl(RESTART_PORT, STOP_CODE, DSV_ZERO, NMT_NONE, 1'b0);
        check(if_running, 1'b0);
        check(can_rx_ready, 1'b0);
        tx_message_count = 4'h1;
        tx_handover_counter = tx_handover_counter + 8'h01;
        tick(10);
        check(tx_handover_counter_ret, tx_handover_counter - 8'h01);
        ctl(RESTART_PORT, RUN_CODE, DSV_ZERO, NMT_NONE, 1'b0);
        check(if_running, 1'b1);
        wait_ret();
        check(100'(u_node.got.size()), 100'h7);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_ctl();
        complete_run();
    end
endmodule // tb
